// File: rtl/sink_link_status_ber_regs.sv
`timescale 1ns/100ps
// Behaviour
// R1: Control bit 11 at 1 holds the sink transceiver in reset; 0 releases it.
// R2: Control bits 10:8 show the training pattern now in use.
// R3: Control bit 7 at 1 bypasses the descrambler; 0 keeps it active.
// R4: Control bits 23:16 hold link rate in units of 270 Mbps.
// R5: Without controller, control reads only, showing rate and one-hot lane count.
// R6: With controller, status bit 17 follows the transceiver retune busy input; without, it reads 0.
// R7: Status bit 16 sets on symbol lock loss, clears only by writing 1.
// R8: Status bit 8 shows inter-lane alignment achieved.
// R9: Status bits 7:4 show symbol lock of lanes 3 to 0.
// R10: Status bits 3:0 show clock recovery lock of lanes 3 to 0.
// R11: In single-lane test, lock bits of untested lanes read 1.
// R12: Test bit 20 enables single-lane test; bits 22:21 pick the lane.
// R13: Test bits 16 to 19 clear visible counters of lanes 0 to 3; read 0.
// R14: Test bits 24 to 27 clear internal counters of lanes 0 to 3; read 0.
// R15: Each lane has a three-bit pattern select at bits 4:2 through 13:11.
// R16: Test bits 1:0 choose counted errors: both, disparity, code, reserved.
// R17: Visible 15-bit counters sit at index 3 and 4 and leave the block.
// R18: Internal 15-bit counters sit at index 6 and 7, never reported out.
// R19: A 24-bit timestamp advances every 100 us; upper byte reads zero.
// R20: Writing 1 to control bit 13 requests a retune; bit reads 0.
// R21: Counters step once per selected error, saturate, and zero on clear.
// R22: Lock bits follow lanes live; loss sets when a used lane drops lock.
module sink_link_status_ber_regs
	import sink_link_pkg::*;
#(
	parameter bit CONTROLLER_USED = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire logic [ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// Lane condition from the transceiver, asynchronous.
	input wire logic [LANES-1:0] clockRecoveredLane,
	input wire logic [LANES-1:0] symbolLockedLane,
	input wire logic lanesDeskewed,
	input wire logic transceiverRetunePending,
	// Receive datapath, on this clock.
	input wire logic [2:0] trainingPatternNow,
	input wire logic [LANES-1:0] disparityError,
	input wire logic [LANES-1:0] codeError,
	input wire logic [7:0] trainedLineRate,
	input wire logic [4:0] trainedLaneCount,
	// Transceiver control.
	output logic transceiverHoldInReset,
	output logic descramblerBypass,
	output logic [7:0] lineRate,
	output logic [4:0] laneCount,
	output logic retuneLineRate,
	// Test control.
	output logic singleLaneTestOn,
	output logic [1:0] singleLaneTestPick,
	output logic [3*LANES-1:0] lanePatternSelect,
	// Visible error counts, lane 0 in the low bits.
	output logic [CNT_W*LANES-1:0] visibleErrorCount
);

	// ----------------------------------------
	// Reset release.
	// ----------------------------------------
	logic rstMeta_ff;
	logic rstSync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	// ----------------------------------------
	// Lane condition synchronisers.
	// ----------------------------------------
	logic [LANES-1:0] cdrLock;
	logic [LANES-1:0] symLock;
	logic deskewed;
	logic retuneBusy;

	pin_sync #(.WIDTH(2*LANES+2)) u_pin_sync (
		.clk(clk),
		.rstN(rstSync_ff),
		.pinIn({transceiverRetunePending, lanesDeskewed, symbolLockedLane, clockRecoveredLane}),
		.levelOut({retuneBusy, deskewed, symLock, cdrLock})
	);

	// ----------------------------------------
	// Bus decode.
	// ----------------------------------------
	bus_state_t busState_ff;
	logic [31:0] readData_ff;
	logic waitRequest_ff;
	logic [2:0] regIndex;
	logic [31:0] byteMask;
	logic [31:0] wrBits;
	logic wrTake;
	logic wrControl;
	logic wrStatus;
	logic wrTest;

	assign regIndex = avsAddress[4:2];
	assign byteMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}}, {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
	assign wrBits = avsWriteData & byteMask;
	assign wrTake = (busState_ff == BUS_ACK) && avsWrite;
	assign wrControl = wrTake && regIndex == IDX_LINK_CONTROL && CONTROLLER_USED; // R5
	assign wrStatus = wrTake && regIndex == IDX_LINK_STATUS;
	assign wrTest = wrTake && regIndex == IDX_TEST_CONTROL;

	// ----------------------------------------
	// Link control register.
	// ----------------------------------------
	logic holdReset_ff;
	logic descrBypass_ff;
	logic [7:0] rate_ff;
	logic [4:0] lanes_ff;
	logic retune_ff;

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			holdReset_ff <= 1'b0;
			descrBypass_ff <= 1'b0;
			rate_ff <= RESET_RATE;
			lanes_ff <= RESET_LANES;
		end else if (!CONTROLLER_USED) begin
			holdReset_ff <= 1'b0;
			descrBypass_ff <= 1'b0;
			rate_ff <= trainedLineRate; // R5
			lanes_ff <= trainedLaneCount; // R5
		end else if (wrControl) begin
			if (avsByteEnable[1]) begin
				holdReset_ff <= avsWriteData[CTL_XCVR_RESET]; // R1
			end
			if (avsByteEnable[0]) begin
				descrBypass_ff <= avsWriteData[CTL_DESCR_BYPASS]; // R3
				lanes_ff <= avsWriteData[CTL_LANES_LSB +: 5];
			end
			if (avsByteEnable[2]) begin
				rate_ff <= avsWriteData[CTL_RATE_LSB +: 8]; // R4
			end
		end
	end

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			retune_ff <= 1'b0;
		end else begin
			retune_ff <= wrControl && wrBits[CTL_RETUNE]; // R20
		end
	end

	// ----------------------------------------
	// Lanes in use.
	// ----------------------------------------
	logic [LANES-1:0] usedLanes;

	always_comb begin
		unique case (lanes_ff)
			LANES_ONE: usedLanes = 4'h1;
			LANES_TWO: usedLanes = 4'h3;
			LANES_FOUR: usedLanes = 4'hF;
			default: usedLanes = 4'h0;
		endcase
	end

	// ----------------------------------------
	// Error test control register.
	// ----------------------------------------
	logic testOn_ff;
	logic [1:0] testPick_ff;
	logic [3*LANES-1:0] patterns_ff;
	logic [1:0] kind_ff;
	logic [LANES-1:0] clearVisible;
	logic [LANES-1:0] clearInternal;

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			testOn_ff <= 1'b0;
			testPick_ff <= 2'h0;
			patterns_ff <= RESET_PATTERNS;
			kind_ff <= RESET_KIND;
		end else if (wrTest) begin
			if (avsByteEnable[2]) begin
				testOn_ff <= avsWriteData[TST_ON]; // R12
				testPick_ff <= avsWriteData[TST_PICK_LSB +: 2]; // R12
			end
			if (avsByteEnable[0]) begin
				kind_ff <= avsWriteData[TST_KIND_LSB +: 2]; // R16
				patterns_ff[5:0] <= avsWriteData[TST_PATT_LSB +: 6]; // R15
			end
			if (avsByteEnable[1]) begin
				patterns_ff[11:6] <= avsWriteData[TST_PATT_LSB+6 +: 6]; // R15
			end
		end
	end

	assign clearVisible = wrTest ? wrBits[TST_CLR_VIS_LSB +: LANES] : 4'h0; // R13
	assign clearInternal = wrTest ? wrBits[TST_CLR_INT_LSB +: LANES] : 4'h0; // R14

	// ----------------------------------------
	// Status: live lock view and sticky loss flag.
	// ----------------------------------------
	logic [LANES-1:0] symLockPrev_ff;
	logic syncLoss_ff;
	logic [LANES-1:0] pickMask;
	logic [LANES-1:0] cdrShow;
	logic [LANES-1:0] symShow;
	logic lossEvent;

	assign pickMask = 4'h1 << testPick_ff;
	assign cdrShow = testOn_ff ? (cdrLock | ~pickMask) : cdrLock; // R10 R11
	assign symShow = testOn_ff ? (symLock | ~pickMask) : symLock; // R9 R11
	assign lossEvent = |(symLockPrev_ff & ~symLock & usedLanes); // R22

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			symLockPrev_ff <= '0;
		end else begin
			symLockPrev_ff <= symLock;
		end
	end

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			syncLoss_ff <= 1'b0;
		end else if (lossEvent) begin // R7
			syncLoss_ff <= 1'b1;
		end else if (wrStatus && wrBits[STS_SYNC_LOSS]) begin // R7
			syncLoss_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Error counters, visible and internal per lane.
	// ----------------------------------------
	logic [CNT_W-1:0] visCount [LANES];
	logic [CNT_W-1:0] intCount [LANES];

	for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
		logic laneEvent;

		always_comb begin
			unique case (kind_ff)
				KIND_BOTH: laneEvent = disparityError[lane] | codeError[lane]; // R16
				KIND_DISPARITY: laneEvent = disparityError[lane]; // R16
				KIND_CODE: laneEvent = codeError[lane]; // R16
				default: laneEvent = 1'b0;
			endcase
		end

		lane_error_counter u_visible (
			.clk(clk),
			.rstN(rstSync_ff),
			.errorEvent(laneEvent),
			.clear(clearVisible[lane]),
			.count(visCount[lane])
		);

		lane_error_counter u_internal (
			.clk(clk),
			.rstN(rstSync_ff),
			.errorEvent(laneEvent),
			.clear(clearInternal[lane]),
			.count(intCount[lane])
		);

		assign visibleErrorCount[lane*CNT_W +: CNT_W] = visCount[lane]; // R17
	end

	// ----------------------------------------
	// Timestamp.
	// ----------------------------------------
	logic [10:0] tickDiv_ff;
	logic [TS_W-1:0] ticks_ff;

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			tickDiv_ff <= '0;
			ticks_ff <= '0;
		end else if (tickDiv_ff == TICK_LAST) begin // R19
			tickDiv_ff <= '0;
			ticks_ff <= ticks_ff + 1'b1;
		end else begin
			tickDiv_ff <= tickDiv_ff + 1'b1;
		end
	end

	// ----------------------------------------
	// Read view.
	// ----------------------------------------
	logic [31:0] controlWord;
	logic [31:0] statusWord;
	logic [31:0] testWord;
	logic [31:0] readWord;

	always_comb begin
		controlWord = '0;
		controlWord[CTL_RATE_LSB +: 8] = rate_ff; // R4 R5
		controlWord[CTL_LANES_LSB +: 5] = lanes_ff; // R5
		if (CONTROLLER_USED) begin
			controlWord[CTL_XCVR_RESET] = holdReset_ff;
			controlWord[CTL_TP_LSB +: 3] = trainingPatternNow; // R2
			controlWord[CTL_DESCR_BYPASS] = descrBypass_ff;
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[STS_CDR_LSB +: LANES] = cdrShow; // R10
		statusWord[STS_SYM_LSB +: LANES] = symShow; // R9
		statusWord[STS_DESKEW] = deskewed; // R8
		statusWord[STS_SYNC_LOSS] = syncLoss_ff;
		statusWord[STS_BUSY] = CONTROLLER_USED && retuneBusy; // R6
	end

	always_comb begin
		testWord = '0;
		testWord[TST_KIND_LSB +: 2] = kind_ff;
		testWord[TST_PATT_LSB +: 3*LANES] = patterns_ff;
		testWord[TST_ON] = testOn_ff;
		testWord[TST_PICK_LSB +: 2] = testPick_ff;
	end

	always_comb begin
		unique case (regIndex)
			IDX_LINK_CONTROL: readWord = controlWord;
			IDX_LINK_STATUS: readWord = statusWord;
			IDX_TEST_CONTROL: readWord = testWord;
			IDX_VIS_CNT_LOW: readWord = {1'b0, visCount[1], 1'b0, visCount[0]}; // R17
			IDX_VIS_CNT_HIGH: readWord = {1'b0, visCount[3], 1'b0, visCount[2]}; // R17
			IDX_TICKS: readWord = {8'h00, ticks_ff}; // R19
			IDX_INT_CNT_LOW: readWord = {1'b0, intCount[1], 1'b0, intCount[0]}; // R18
			IDX_INT_CNT_HIGH: readWord = {1'b0, intCount[3], 1'b0, intCount[2]}; // R18
		endcase
	end

	// ----------------------------------------
	// Bus answer: one wait cycle, then an acknowledge cycle.
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			busState_ff <= BUS_IDLE;
			waitRequest_ff <= 1'b1;
		end else begin
			unique case (busState_ff)
				BUS_IDLE: begin
					if (avsRead || avsWrite) begin
						busState_ff <= BUS_ACK;
						waitRequest_ff <= 1'b0;
					end
				end
				BUS_ACK: begin
					busState_ff <= BUS_IDLE;
					waitRequest_ff <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			readData_ff <= '0;
		end else if (busState_ff == BUS_IDLE && avsRead) begin
			readData_ff <= readWord;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign avsReadData = readData_ff;
	assign avsWaitRequest = waitRequest_ff;
	assign transceiverHoldInReset = holdReset_ff;
	assign descramblerBypass = descrBypass_ff;
	assign lineRate = rate_ff;
	assign laneCount = lanes_ff;
	assign retuneLineRate = retune_ff;
	assign singleLaneTestOn = testOn_ff;
	assign singleLaneTestPick = testPick_ff;
	assign lanePatternSelect = patterns_ff;

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	a_loss_sets: assert property (@(posedge clk) disable iff (!rstSync_ff) // R7
		lossEvent |=> syncLoss_ff) else $error("Loss flag did not set.");
	a_loss_sticky: assert property (@(posedge clk) disable iff (!rstSync_ff) // R7
		(syncLoss_ff && !(wrStatus && wrBits[STS_SYNC_LOSS])) |=> syncLoss_ff) else $error("Loss flag fell alone.");
	a_retune_pulse: assert property (@(posedge clk) disable iff (!rstSync_ff) // R20
		(wrControl && wrBits[CTL_RETUNE]) |=> retuneLineRate ##1 !retuneLineRate) else $error("Retune pulse wrong.");
	a_hold_reset: assert property (@(posedge clk) disable iff (!rstSync_ff) // R1
		(wrControl && avsByteEnable[1]) |=> transceiverHoldInReset == $past(avsWriteData[CTL_XCVR_RESET]))
		else $error("Hold-in-reset not stored.");
	a_forced_lock: assert property (@(posedge clk) disable iff (!rstSync_ff) // R11
		testOn_ff |-> ((statusWord[7:4] | pickMask) == 4'hF && (statusWord[3:0] | pickMask) == 4'hF))
		else $error("Untested lane lock not forced.");
	a_tick_step: assert property (@(posedge clk) disable iff (!rstSync_ff) // R19
		(tickDiv_ff == TICK_LAST) |=> ticks_ff == $past(ticks_ff) + 1'b1 && tickDiv_ff == '0)
		else $error("Timestamp tick wrong.");
	a_tick_still: assert property (@(posedge clk) disable iff (!rstSync_ff) // R19
		(tickDiv_ff != TICK_LAST) |=> $stable(ticks_ff)) else $error("Timestamp moved early.");
	a_bus_answer: assert property (@(posedge clk) disable iff (!rstSync_ff)
		(busState_ff == BUS_IDLE && (avsRead || avsWrite)) |=> !avsWaitRequest ##1 avsWaitRequest)
		else $error("Bus answer timing wrong.");
	a_read_mode: assert property (@(posedge clk) disable iff (!rstSync_ff) // R5
		!CONTROLLER_USED |-> controlWord[15:5] == '0 && !transceiverHoldInReset) else $error("Read-only control changed.");

endmodule : sink_link_status_ber_regs

// File: rtl/sink_link_pkg.sv
package sink_link_pkg;

	// ----------------------------------------
	// Geometry.
	// ----------------------------------------
	localparam int LANES = 4;
	localparam int CNT_W = 15;
	localparam int TS_W = 24;
	localparam int ADDR_W = 5;

	// ----------------------------------------
	// Register indices; byte address is four times the index.
	// ----------------------------------------
	localparam logic [2:0] IDX_LINK_CONTROL = 3'h0;
	localparam logic [2:0] IDX_LINK_STATUS = 3'h1;
	localparam logic [2:0] IDX_TEST_CONTROL = 3'h2;
	localparam logic [2:0] IDX_VIS_CNT_LOW = 3'h3;
	localparam logic [2:0] IDX_VIS_CNT_HIGH = 3'h4;
	localparam logic [2:0] IDX_TICKS = 3'h5;
	localparam logic [2:0] IDX_INT_CNT_LOW = 3'h6;
	localparam logic [2:0] IDX_INT_CNT_HIGH = 3'h7;

	// ----------------------------------------
	// Link control fields.
	// ----------------------------------------
	localparam int CTL_LANES_LSB = 0;
	localparam int CTL_DESCR_BYPASS = 7;
	localparam int CTL_TP_LSB = 8;
	localparam int CTL_XCVR_RESET = 11;
	localparam int CTL_RETUNE = 13;
	localparam int CTL_RATE_LSB = 16;
	localparam logic [7:0] RATE_162 = 8'h06;
	localparam logic [7:0] RATE_270 = 8'h0A;
	localparam logic [7:0] RATE_540 = 8'h14;
	localparam logic [7:0] RESET_RATE = RATE_162;
	localparam logic [4:0] LANES_ONE = 5'h01;
	localparam logic [4:0] LANES_TWO = 5'h02;
	localparam logic [4:0] LANES_FOUR = 5'h04;
	localparam logic [4:0] RESET_LANES = LANES_ONE;

	// ----------------------------------------
	// Link status fields.
	// ----------------------------------------
	localparam int STS_CDR_LSB = 0;
	localparam int STS_SYM_LSB = 4;
	localparam int STS_DESKEW = 8;
	localparam int STS_SYNC_LOSS = 16;
	localparam int STS_BUSY = 17;

	// ----------------------------------------
	// Error test control fields.
	// ----------------------------------------
	localparam int TST_KIND_LSB = 0;
	localparam int TST_PATT_LSB = 2;
	localparam int TST_CLR_VIS_LSB = 16;
	localparam int TST_ON = 20;
	localparam int TST_PICK_LSB = 21;
	localparam int TST_CLR_INT_LSB = 24;
	localparam logic [1:0] KIND_BOTH = 2'h0;
	localparam logic [1:0] KIND_DISPARITY = 2'h1;
	localparam logic [1:0] KIND_CODE = 2'h2;
	localparam logic [11:0] RESET_PATTERNS = 12'h000;
	localparam logic [1:0] RESET_KIND = KIND_BOTH;

	// ----------------------------------------
	// Counter layout inside a count register.
	// ----------------------------------------
	localparam int CNT_HI_LSB = 16;

	// ----------------------------------------
	// Timestamp tick.
	// ----------------------------------------
	localparam int TICK_US = 100;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);

	// ----------------------------------------
	// Bus answer state.
	// ----------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;

endpackage : sink_link_pkg

// File: rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
	import sink_link_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstN,
	// Asynchronous level in, filtered level out.
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] levelOut
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] level_ff;

	// ----------------------------------------
	// A change counts once stages two and three agree.
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end else begin
			stage1_ff <= pinIn;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			level_ff <= '0;
		end else begin
			level_ff <= (stage2_ff & stage3_ff) | (level_ff & (stage2_ff | stage3_ff));
		end
	end

	assign levelOut = level_ff;

endmodule : pin_sync

// File: rtl/lane_error_counter.sv
`timescale 1ns/100ps
module lane_error_counter
	import sink_link_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstN,
	// Event and clear.
	input wire logic errorEvent,
	input wire logic clear,
	// Count.
	output logic [CNT_W-1:0] count
);

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	logic [CNT_W-1:0] count_ff;

	// ----------------------------------------
	// Saturating count; a clear returns it to zero.
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count_ff <= '0;
		end else if (clear) begin // R21
			count_ff <= '0;
		end else if (errorEvent && count_ff != CNT_MAX) begin // R21
			count_ff <= count_ff + 1'b1;
		end
	end

	assign count = count_ff;

	a_count_clear: assert property (@(posedge clk) disable iff (!rstN) clear |=> count_ff == '0) else $error("Counter not zero after clear."); // R21
	a_count_saturate: assert property (@(posedge clk) disable iff (!rstN) // R21
		(count_ff == CNT_MAX && !clear) |=> count_ff == CNT_MAX) else $error("Counter wrapped past maximum.");
	a_count_step: assert property (@(posedge clk) disable iff (!rstN) // R21
		(errorEvent && !clear && count_ff != CNT_MAX) |=> count_ff == $past(count_ff) + 1'b1) else $error("Counter missed an event.");

endmodule : lane_error_counter

// File: bench/lane_source_model.sv
`timescale 1ns/100ps
module lane_source_model (
	// Clock.
	input wire logic clk,
	// Wanted lane condition.
	input wire logic [3:0] crWant,
	input wire logic [3:0] symWant,
	input wire logic alignWant,
	// Error burst request.
	input wire logic burstGo,
	input wire logic [3:0] burstLanes,
	input wire logic [7:0] burstLen,
	// Lane condition and error events.
	output logic [3:0] clockRecoveredLane,
	output logic [3:0] symbolLockedLane,
	output logic lanesDeskewed,
	output logic [3:0] disparityError,
	output logic [3:0] codeError
);
	logic [7:0] left = 8'h00;
	assign clockRecoveredLane = crWant;
	assign symbolLockedLane = symWant;
	assign lanesDeskewed = alignWant;
	// Disparity errors only, so a code-only count selection must stay at zero.
	assign disparityError = (left != 8'h00) ? burstLanes : 4'h0;
	assign codeError = 4'h0;
	always @(posedge clk) begin
		if (burstGo) begin
			left <= burstLen;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
endmodule : lane_source_model

// File: bench/sink_link_status_ber_regs_tb.sv
`timescale 1ns/100ps
module sink_link_status_ber_regs_tb;
	import sink_link_pkg::*;
	logic clk = 1'b0;
	logic rst_n, avsRead, avsWrite, avsWaitRequest, retunePend, hold, bypass, retune, testOn, alignWant, burstGo;
	logic [4:0] avsAddress, laneCount;
	logic [31:0] avsWriteData, avsReadData, q, q0;
	logic [3:0] cr, sym, disp, code, crWant, symWant;
	logic [2:0] tpNow;
	logic [7:0] lineRate;
	logic [1:0] pick;
	logic [11:0] patt;
	logic [59:0] visCnt;
	int fails = 0;
	int checked = 0;
	int retunes = 0;
	logic dsk;
	logic [31:0] roData;
	logic [7:0] roRate;
	logic [4:0] roLanes;

	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (retune === 1'b1) begin
			retunes++;
		end
	end

	lane_source_model i_lane_source_model (.clk(clk), .crWant(crWant), .symWant(symWant), .alignWant(alignWant),
		.burstGo(burstGo), .burstLanes(4'h2), .burstLen(8'h04), .clockRecoveredLane(cr), .symbolLockedLane(sym),
		.lanesDeskewed(dsk), .disparityError(disp), .codeError(code));
	sink_link_status_ber_regs i_sink_link_status_ber_regs (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .clockRecoveredLane(cr),
		.symbolLockedLane(sym), .lanesDeskewed(dsk), .transceiverRetunePending(retunePend),
		.trainingPatternNow(tpNow), .disparityError(disp), .codeError(code), .trainedLineRate(8'h0A),
		.trainedLaneCount(5'h02), .transceiverHoldInReset(hold), .descramblerBypass(bypass), .lineRate(lineRate),
		.laneCount(laneCount), .retuneLineRate(retune), .singleLaneTestOn(testOn), .singleLaneTestPick(pick),
		.lanePatternSelect(patt), .visibleErrorCount(visCnt));
	sink_link_status_ber_regs #(.CONTROLLER_USED(1'b0)) i_sink_link_status_ber_regs_ro (.clk(clk), .rst_n(rst_n),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(4'hF), .avsReadData(roData), .avsWaitRequest(), .clockRecoveredLane(cr),
		.symbolLockedLane(sym), .lanesDeskewed(dsk), .transceiverRetunePending(retunePend),
		.trainingPatternNow(tpNow), .disparityError(disp), .codeError(code), .trainedLineRate(8'h0A),
		.trainedLaneCount(5'h02), .transceiverHoldInReset(), .descramblerBypass(), .lineRate(roRate),
		.laneCount(roLanes), .retuneLineRate(), .singleLaneTestOn(), .singleLaneTestPick(),
		.lanePatternSelect(), .visibleErrorCount());

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : check

	// One bus cycle, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		avsAddress <= {idx, 2'b00};
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWriteData <= d;
		@(posedge clk);
		while (avsWaitRequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				fails++;
				finish_test();
			end
			@(posedge clk);
		end
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rdchk(input string what, input logic [2:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0, q);
		check(what, exp, q);
	endtask : rdchk

	task automatic test_reset;
		logic [31:0] exp [8];
		exp = '{32'h00060001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) begin
			rdchk("reset value", 3'(i), exp[i]);
		end
		bus(1'b0, 3'h5, 32'h0, q0);
		repeat (1997) @(posedge clk);
		rdchk("ticks", 3'h5, {8'h00, q0[23:0] + 24'h1});
		$display("test reset and ticks done");
	endtask : test_reset

	task automatic test_control;
		tpNow <= 3'h7;
		bus(1'b1, 3'h0, 32'h00142884, q);
		repeat (2) @(posedge clk);
		check("control outputs", {17'h0, 2'b11, 8'h14, 5'h04}, {17'h0, hold, bypass, lineRate, laneCount});
		rdchk("control", 3'h0, 32'h00140F84);
		bus(1'b1, 3'h0, 32'h00140004, q);
		repeat (2) @(posedge clk);
		check("release", 32'h1, {30'h0, hold, bypass} + 32'(retunes));
		$display("test control done");
	endtask : test_control

	task automatic test_status;
		crWant <= 4'hA;
		symWant <= 4'hF;
		alignWant <= 1'b1;
		retunePend <= 1'b1;
		repeat (8) @(posedge clk);
		rdchk("status", 3'h1, 32'h000201FA);
		crWant <= 4'hF;
		symWant <= 4'hE;
		repeat (8) @(posedge clk);
		symWant <= 4'hF;
		repeat (8) @(posedge clk);
		rdchk("loss held", 3'h1, 32'h000301FF);
		bus(1'b1, 3'h1, 32'h00010000, q);
		rdchk("loss cleared", 3'h1, 32'h000201FF);
		$display("test status done");
	endtask : test_status

	task automatic test_single;
		crWant <= 4'h0;
		symWant <= 4'h0;
		repeat (8) @(posedge clk);
		bus(1'b1, 3'h2, 32'h015118AC, q);
		rdchk("test control", 3'h2, 32'h005018AC);
		check("test outputs", {17'h0, 1'b1, 2'h2, 12'h62B}, {17'h0, testOn, pick, patt});
		rdchk("forced locks", 3'h1, 32'h000301BB);
		bus(1'b1, 3'h2, 32'h0, q);
		$display("test single lane done");
	endtask : test_single

	task automatic test_counters;
		logic [31:0] e;
		for (int k = 3; k >= 0; k--) begin
			e = (k < 2) ? 32'h00040000 : 32'h0;
			bus(1'b1, 3'h2, 32'h02020000 | 32'(k), q);
			burstGo <= 1'b1;
			@(posedge clk);
			burstGo <= 1'b0;
			repeat (8) @(posedge clk);
			rdchk("visible count", 3'h3, e);
			rdchk("internal count", 3'h6, e);
			check("count port", e >> 16, {17'h0, visCnt[29:15]});
		end
		bus(1'b1, 3'h2, 32'h00020000, q);
		rdchk("visible cleared", 3'h3, 32'h0);
		rdchk("internal kept", 3'h6, 32'h00040000);
		burstGo <= 1'b1;
		repeat (32770) @(posedge clk);
		burstGo <= 1'b0;
		repeat (8) @(posedge clk);
		rdchk("visible saturated", 3'h3, 32'h7FFF0000);
		rdchk("internal saturated", 3'h6, 32'h7FFF0000);
		$display("test counters done");
	endtask : test_counters

	task automatic test_read_only;
		bus(1'b1, 3'h0, 32'hFFFFFFFF, q);
		bus(1'b0, 3'h0, 32'h0, q);
		check("read-only control", 32'h000A0002, roData);
		check("read-only outputs", {19'h0, 8'h0A, 5'h02}, {19'h0, roRate, roLanes});
		$display("test read-only control done");
	endtask : test_read_only

	initial begin
		rst_n = 1'b0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddress = 5'h00;
		avsWriteData = 32'h0;
		tpNow = 3'h0;
		retunePend = 1'b0;
		crWant = 4'h0;
		symWant = 4'h0;
		alignWant = 1'b0;
		burstGo = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		test_reset();
		test_control();
		test_status();
		test_single();
		test_counters();
		test_read_only();
		finish_test();
	end
endmodule : sink_link_status_ber_regs_tb
